// File: src/tcp_top.sv
// Timer/counter with edge select, comparator source and shared prescaler
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
// Function
// - With the clock source select bit low and prescaler assignment 1 the counter adds one per cycle.
// - A write to the count blocks incrementing for the next two cycles.
// - Pin edges count when source select, comparator clock and pin enable are set.
// - The edge select bit picks rising (0) or falling (1) pin edges.
// - The comparator output counts when source select is set and comparator clock is clear.
// - The one prescaler serves the counter (assignment 0) or the watchdog (1).
// - The prescaler count has no register address.
// - On the counter side the ratio field divides by 2 up to 256.
// - The count is an 8-bit read/write register at 01h, not reset.
// - With source select set the count pin direction is forced to input.
// - The option register holds the timer bits and resets to all ones.
// - Comparator clock select is bit 4 of the register at 08h, reset to ones.
// - Count writes clear the prescaler on the counter side, watchdog clears on the other.
// - The prescaler is all zeros after reset.
// - Pin and comparator events are synchronised before they count.
module tcp_top (
  input  wire logic       core_clk,          // Instruction-cycle clock
  input  wire logic       srst,              // Synchronous reset
  input  wire logic [7:0] reg_addr,          // Register address
  input  wire logic [7:0] reg_wdata,         // Register write data
  input  wire logic       reg_wr,            // Write strobe
  input  wire logic       reg_rd,            // Read strobe
  output logic      [7:0] reg_rdata,         // Read data, cycle after
  input  wire logic       external_count_pin,// Count pin, asynchronous
  input  wire logic       comparator_out,    // Comparator output, async
  input  wire logic       watchdog_tick,     // Watchdog oscillator event
  input  wire logic       watchdog_clear,    // Watchdog clear pulse
  output logic            watchdog_event,    // Prescaled watchdog event
  output logic            pin_dir_override,  // Count pin forced to input
  output logic      [7:0] timer_count_value  // Current count
);
  import tcp_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [7:0] option_settings;
    logic [7:0] comparator_one_control;
    logic [7:0] comparator_two_control;
    logic [7:0] count;
    logic [1:0] inhibit;
    logic [7:0] rdata;
    logic       wdt_evt;
    logic       pin_ovr;
    logic [2:0] pin_sync;
    logic       pin_level;
    logic [2:0] cmp_sync;
    logic       cmp_level;
  } tcp_state_t;

  tcp_state_t state;
  tcp_state_t next_state;

  tcp_pre_if pre_link ();

  // Option and comparator fields
  logic       clock_source_select;
  logic       source_edge_select;
  logic       prescaler_assignment;
  logic [2:0] prescale_ratio;
  logic       comparator_timer_clock_select;
  logic       comparator_output_pin_enable;
  tcp_src_t   src;
  logic       pin_new;
  logic       cmp_new;
  logic       pin_edge;
  logic       cmp_edge;
  logic       src_tick;
  logic       count_tick;
  logic       count_wr;

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  always_comb begin
    clock_source_select  = state.option_settings[TCP_OPT_CS];
    source_edge_select   = state.option_settings[TCP_OPT_SE];
    prescaler_assignment = state.option_settings[TCP_OPT_PSA];
    prescale_ratio       =
      state.option_settings[TCP_OPT_PS_H:TCP_OPT_PS_L];
    comparator_timer_clock_select =
      state.comparator_one_control[TCP_CMP_CLOCK_SOURCE_SELECT];
    comparator_output_pin_enable =
      state.comparator_one_control[TCP_CMP_OUTEN];
  end

  // Counting source selection
  always_comb begin
    if (!clock_source_select) begin
      src = TCP_SRC_CYCLE;
    end else if (!comparator_timer_clock_select) begin
      src = TCP_SRC_CMP;
    end else if (comparator_output_pin_enable) begin
      src = TCP_SRC_PIN;
    end else begin
      src = TCP_SRC_NONE;
    end
  end

  // Levels accepted once the last two sync stages agree
  always_comb begin
    pin_new = (state.pin_sync[1] == state.pin_sync[2]) ?
              state.pin_sync[2] : state.pin_level;
    cmp_new = (state.cmp_sync[1] == state.cmp_sync[2]) ?
              state.cmp_sync[2] : state.cmp_level;
    pin_edge = source_edge_select ?
               (state.pin_level && !pin_new) :
               (!state.pin_level && pin_new);
    cmp_edge = !state.cmp_level && cmp_new;
  end

  // Raw event feeding the counter or its prescaler
  always_comb begin
    case (src)
      TCP_SRC_CYCLE: src_tick = 1'b1;
      TCP_SRC_PIN:   src_tick = pin_edge;
      TCP_SRC_CMP:   src_tick = cmp_edge;
      TCP_SRC_NONE:  src_tick = 1'b0;
      default:       src_tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescaler link: counter side or watchdog side, never both
  always_comb begin
    count_wr       = reg_wr && (reg_addr == TCP_ADDR_COUNT);
    pre_link.to_wdt = prescaler_assignment;
    pre_link.ratio  = prescale_ratio;
    pre_link.tick   = prescaler_assignment ? watchdog_tick
                                           : src_tick;
    pre_link.clear  = prescaler_assignment ? watchdog_clear
                                           : count_wr;
  end

  // Prescaler count lives only inside, with no address
  tcp_prescaler #(
    .W (TCP_PRE_W)
  ) u_pre (
    .core_clk (core_clk),
    .srst     (srst),
    .pre      (pre_link.pre)
  );

  // Increment event after optional prescaling
  always_comb begin
    count_tick = prescaler_assignment ? src_tick
                                      : pre_link.pulse;
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_state = state;

    // Synchronisers: first stage feeds only the second
    next_state.pin_sync  = {state.pin_sync[1:0], external_count_pin};
    next_state.cmp_sync  = {state.cmp_sync[1:0], comparator_out};
    next_state.pin_level = pin_new;
    next_state.cmp_level = cmp_new;

    // Counter with write inhibit and wrap
    if (count_wr) begin
      next_state.count   = reg_wdata;
      next_state.inhibit = TCP_WR_INHIBIT;
    end else if (state.inhibit != 2'h0) begin
      next_state.inhibit = state.inhibit - 2'h1;
    end else if (count_tick) begin
      next_state.count = state.count + 8'h01;
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        TCP_ADDR_CMP1:   next_state.comparator_one_control = reg_wdata;
        TCP_ADDR_CMP2:   next_state.comparator_two_control = reg_wdata;
        TCP_ADDR_OPTION: next_state.option_settings = reg_wdata;
        default:         next_state.rdata = state.rdata;
      endcase
    end

    // Read data, valid in the cycle after the strobe only
    next_state.rdata = TCP_READ_ZERO;
    if (reg_rd) begin
      case (reg_addr)
        TCP_ADDR_COUNT: next_state.rdata = state.count;
        TCP_ADDR_CMP1:  next_state.rdata = state.comparator_one_control;
        TCP_ADDR_CMP2:  next_state.rdata = state.comparator_two_control;
        default:        next_state.rdata = TCP_READ_ZERO;
      endcase
    end

    // Watchdog event and pin override outputs
    next_state.wdt_evt = prescaler_assignment && pre_link.pulse;
    next_state.pin_ovr = next_state.option_settings[TCP_OPT_CS];

    // Reset leaves the count untouched
    if (srst) begin
      next_state.option_settings        = TCP_OPTION_RST;
      next_state.comparator_one_control = TCP_CMP_RST;
      next_state.comparator_two_control = TCP_CMP_RST;
      next_state.inhibit   = 2'h0;
      next_state.rdata     = TCP_READ_ZERO;
      next_state.wdt_evt   = 1'b0;
      next_state.pin_ovr   = TCP_OPTION_RST[TCP_OPT_CS];
      next_state.pin_sync  = 3'h0;
      next_state.pin_level = 1'b0;
      next_state.cmp_sync  = 3'h0;
      next_state.cmp_level = 1'b0;
      next_state.count     = state.count;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  always_comb begin
    reg_rdata         = state.rdata;
    watchdog_event    = state.wdt_evt;
    pin_dir_override  = state.pin_ovr;
    timer_count_value = state.count;
  end

endmodule // tcp_top

// File: src/tcp_pkg.sv
// Shared constants and types of the timer/counter with prescaler
package tcp_pkg;

  // Register offsets on the plain register port
  localparam logic [7:0] TCP_ADDR_COUNT  = 8'h01;
  localparam logic [7:0] TCP_ADDR_CMP1   = 8'h08;
  localparam logic [7:0] TCP_ADDR_CMP2   = 8'h0b;
  localparam logic [7:0] TCP_ADDR_OPTION = 8'h10;

  // Reset values
  localparam logic [7:0] TCP_OPTION_RST = 8'hff;
  localparam logic [7:0] TCP_CMP_RST    = 8'hff;
  localparam logic [7:0] TCP_READ_ZERO  = 8'h00;

  // Field positions in the option register
  localparam int TCP_OPT_CS   = 5;
  localparam int TCP_OPT_SE   = 4;
  localparam int TCP_OPT_PSA  = 3;
  localparam int TCP_OPT_PS_H = 2;
  localparam int TCP_OPT_PS_L = 0;

  // Field positions in the first comparator control register
  localparam int TCP_CMP_OUTEN = 6;
  localparam int TCP_CMP_CLOCK_SOURCE_SELECT  = 4;

  // Cycles of increment suppression after a count write
  localparam logic [1:0] TCP_WR_INHIBIT = 2'h2;

  // Prescaler width and ratio field width
  localparam int TCP_PRE_W   = 8;
  localparam int TCP_RATIO_W = 3;

  // Sources that feed the counter
  typedef enum logic [1:0] {
    TCP_SRC_CYCLE,
    TCP_SRC_PIN,
    TCP_SRC_CMP,
    TCP_SRC_NONE
  } tcp_src_t;

endpackage

// File: src/tcp_pre_if.sv
// Carrier between the timer core and its shared prescaler
`timescale 1ns/1ps
interface tcp_pre_if;
  logic       tick;   // Input event to divide
  logic       clear;  // Zero the prescaler
  logic       to_wdt; // Prescaler serves the watchdog
  logic [2:0] ratio;  // Prescale ratio field
  logic       pulse;  // Divided output event

  modport core (output tick, output clear, output to_wdt,
                output ratio, input pulse);
  modport pre  (input tick, input clear, input to_wdt,
                input ratio, output pulse);
endinterface

// File: src/tcp_prescaler.sv
// Shared 8-bit prescaler, counter side or watchdog side
`timescale 1ns/1ps
module tcp_prescaler #(
  parameter int W = tcp_pkg::TCP_PRE_W
) (
  input wire logic   core_clk, // Instruction-cycle clock
  input wire logic   srst,     // Synchronous reset, active high
  tcp_pre_if.pre     pre       // Link to the timer core
);
  import tcp_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
  } tcp_pre_state_t;

  tcp_pre_state_t state;
  tcp_pre_state_t next_state;

  // Mask of the low bits that must all be ones for one output event
  function automatic logic [W-1:0] tcp_mask(input logic [2:0] ratio,
                                            input logic wdt);
    logic [W-1:0] m;
    m = '0;
    for (int i = 0; i < W; i++) begin
      if (wdt ? (i < int'(ratio)) : (i <= int'(ratio))) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // One output event per 2^(ratio+1) input events on the counter side
  always_comb begin
    pre.pulse = pre.tick &&
                ((state.cnt & tcp_mask(pre.ratio, pre.to_wdt)) ==
                 tcp_mask(pre.ratio, pre.to_wdt));
  end

  // Count, clear, reset to zero
  always_comb begin
    next_state = state;
    if (srst || pre.clear) begin
      next_state.cnt = '0;
    end else if (pre.tick) begin
      next_state.cnt = state.cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    state <= next_state;
  end

endmodule // tcp_prescaler

// File: bench/tcp_far_model.sv
// Far-side model: external count pin and comparator output
`timescale 1ns/1ps
module tcp_far_model (
  input  wire logic core_clk,         // Clock
  output logic      count_pin = 1'b0, // Count pin level
  output logic      cmp_out = 1'b0    // Comparator output level
);
  // Drive a pin level and hold it long enough to pass the synchroniser
  task automatic pin_level(input logic v);
    @(posedge core_clk);
    count_pin <= v;
    repeat (8) @(posedge core_clk);
  endtask
  // One whole comparator pulse, rising edge first
  task automatic cmp_pulse();
    @(posedge core_clk);
    cmp_out <= 1'b1;
    repeat (8) @(posedge core_clk);
    cmp_out <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule // tcp_far_model

// File: bench/tcp_top_sva.sv
// Port checks of the timer/counter with prescaler
`timescale 1ns/1ps
module tcp_top_sva (
  input wire logic       core_clk,         // Clock
  input wire logic       srst,             // Reset
  input wire logic [7:0] reg_addr,         // Address
  input wire logic [7:0] reg_wdata,        // Write data
  input wire logic       reg_wr,           // Write strobe
  input wire logic       reg_rd,           // Read strobe
  input wire logic [7:0] reg_rdata,        // Read data
  input wire logic       watchdog_event,   // Watchdog event
  input wire logic       pin_dir_override, // Pin forced input
  input wire logic [7:0] timer_count_value // Count
);
  import tcp_pkg::*;
  logic [7:0] opt, cmp; // Shadows of option and comparator control
  logic [1:0] wh;       // Writes of the last two cycles
  logic       quiet;    // No write now nor in the last two cycles
  assign quiet = !reg_wr && wh == 2'h0;
  // Shadows follow the register writes
  always_ff @(posedge core_clk) begin
    wh <= srst ? 2'h0 : {wh[0], reg_wr};
    if (srst) opt <= TCP_OPTION_RST;
    else if (reg_wr && reg_addr == TCP_ADDR_OPTION) opt <= reg_wdata;
    if (srst) cmp <= TCP_CMP_RST;
    else if (reg_wr && reg_addr == TCP_ADDR_CMP1) cmp <= reg_wdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_cnt_wr; reg_wr && reg_addr == TCP_ADDR_COUNT; endsequence
  property p_load;
    s_cnt_wr |=> timer_count_value == $past(reg_wdata);
  endproperty
  a_load: assert property (p_load) else $error("count not loaded");
  property p_inhibit;
    s_cnt_wr ##1 !reg_wr |=> timer_count_value == $past(reg_wdata, 2);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("no hold");
  property p_timer;
    !opt[TCP_OPT_CS] && opt[TCP_OPT_PSA] && quiet |=>
      timer_count_value == $past(timer_count_value) + 8'h01;
  endproperty
  a_timer: assert property (p_timer) else $error("no step");
  property p_nocnt;
    opt[TCP_OPT_CS] && cmp[TCP_CMP_CLOCK_SOURCE_SELECT] && !cmp[TCP_CMP_OUTEN] && quiet
      |=> $stable(timer_count_value);
  endproperty
  a_nocnt: assert property (p_nocnt) else $error("count moved");
  property p_wdt_off;
    !opt[TCP_OPT_PSA] && !$past(opt[TCP_OPT_PSA]) |-> !watchdog_event;
  endproperty
  a_wdt_off: assert property (p_wdt_off) else $error("wdt event");
  property p_dir;
    $stable(opt) |-> pin_dir_override == opt[TCP_OPT_CS];
  endproperty
  a_dir: assert property (p_dir) else $error("pin direction");
  property p_rd_zero;
    reg_rd && reg_addr == TCP_ADDR_OPTION |=> reg_rdata == TCP_READ_ZERO;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("option read");
  property p_rd_cmp;
    reg_rd && reg_addr == TCP_ADDR_CMP1 |=> reg_rdata == cmp;
  endproperty
  a_rd_cmp: assert property (p_rd_cmp) else $error("control read");
endmodule // tcp_top_sva
bind tcp_top tcp_top_sva u_sva (.core_clk, .srst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .watchdog_event, .pin_dir_override,
  .timer_count_value);

// File: bench/tcp_top_bench.sv
// Self-checking bench of the timer/counter with prescaler
`timescale 1ns/1ps
module tcp_top_bench;
  import tcp_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic wd_tick = 1'b0, wd_clr = 1'b0, pin, cmp, wd_ev, dir;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, cnt, rv, v1;
  int n_mismatch = 0, num_checks = 0, cyc = 0, n_ev = 0;
  `define TCP_CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    n_mismatch++; $display("Error %0t: %h, want %h", $time, a, e); end end
  tcp_top uut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata(rdata), .external_count_pin(pin), .comparator_out(cmp),
    .watchdog_tick(wd_tick), .watchdog_clear(wd_clr),
    .watchdog_event(wd_ev), .pin_dir_override(dir),
    .timer_count_value(cnt));
  tcp_far_model far (.core_clk, .count_pin(pin), .cmp_out(cmp));
  always #50 core_clk = ~core_clk;
  // Watchdog ticks every other cycle, event count and run ceiling
  always @(posedge core_clk) begin
    wd_tick <= ~wd_tick;
    cyc++;
    if (wd_ev === 1'b1) n_ev++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run;
    end
  end
  // Verdict and end of run
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Register port cycles
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a, rv);
    `TCP_CHK(rv, e)
  endtask
  // Two count reads sep cycles apart; periodic counting makes e exact
  task automatic step(input int sep, input logic [7:0] e);
    repeat (4) @(posedge core_clk);
    rd(TCP_ADDR_COUNT, v1);
    repeat (sep - 2) @(posedge core_clk);
    rd(TCP_ADDR_COUNT, rv);
    `TCP_CHK(rv - v1, e)
  endtask
  // Main sequence; outputs are looked at on the falling edge
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    `TCP_CHK(dir, 1'b1)
    rdc(TCP_ADDR_CMP1, TCP_CMP_RST);
    rdc(TCP_ADDR_CMP2, TCP_CMP_RST);
    rdc(TCP_ADDR_OPTION, TCP_READ_ZERO);
    rdc(8'h02, TCP_READ_ZERO);
    wr(TCP_ADDR_OPTION, 8'hc8);
    wr(TCP_ADDR_COUNT, 8'h5a);
    rdc(TCP_ADDR_COUNT, 8'h5a);
    `TCP_CHK(dir, 1'b0)
    wr(TCP_ADDR_COUNT, 8'hf0);
    step(32, 8'h20);
    `TCP_CHK(rv < v1, 1'b1)
    // Window of two prescaler periods gives exactly two increments
    for (int r = 0; r < 8; r++) begin
      wr(TCP_ADDR_OPTION, 8'hc0 | 8'(r));
      wr(TCP_ADDR_COUNT, 8'h00);
      n_ev = 0;
      step(4 << r, 8'h02);
      `TCP_CHK(n_ev, 0)
    end
    // Watchdog side: no event before the fourth tick after a clear
    wr(TCP_ADDR_OPTION, 8'hca);
    wd_clr <= 1'b1;
    @(posedge core_clk);
    wd_clr <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    n_ev = 0;
    repeat (6) @(negedge core_clk);
    `TCP_CHK(n_ev, 0)
    repeat (2) @(negedge core_clk);
    n_ev = 0;
    repeat (64) @(negedge core_clk);
    `TCP_CHK(n_ev, 8)
    for (int s = 0; s < 2; s++) begin
      wr(TCP_ADDR_OPTION, 8'he8 | 8'(s << 4));
      wr(TCP_ADDR_COUNT, 8'h10);
      far.pin_level(1'b1);
      rdc(TCP_ADDR_COUNT, 8'h11 - 8'(s));
      `TCP_CHK(dir, 1'b1)
      far.pin_level(1'b0);
      rdc(TCP_ADDR_COUNT, 8'h11);
    end
    wr(TCP_ADDR_CMP1, 8'hbf);
    wr(TCP_ADDR_COUNT, 8'h20);
    far.pin_level(1'b1);
    far.pin_level(1'b0);
    rdc(TCP_ADDR_COUNT, 8'h20);
    wr(TCP_ADDR_CMP1, 8'haf);
    repeat (3) far.cmp_pulse();
    far.pin_level(1'b1);
    rdc(TCP_ADDR_COUNT, 8'h23);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    `TCP_CHK(dir, 1'b1)
    rdc(TCP_ADDR_COUNT, 8'h23);
    rdc(TCP_ADDR_CMP1, TCP_CMP_RST);
    complete_run;
  end
endmodule // tcp_top_bench
